// ===== link_reconfig_pkg.sv
// How it works
// R1 - Inhibit bit clear and Gen2 allowed: start Gen2 speed change after first L0 from Detect.
// R2 - Inhibit bit set: never start a speed change; upstream port resets it to one.
// R3 - Target lane code 0..3 selects x1, x2, x4, x8; codes 4 to 6 reserved.
// R4 - Target lane code resets to 7, meaning the advertised maximum width.
// R5 - Software programs a downconfigure target below the negotiated width.
// R6 - Software programs an upconfigure target above negotiated and below initial width.
// R7 - Width change is applied only when software sets the retrain request bit.
// R8 - Software never changes target rate and target width before one retrain.
// R9 - Target lane code returns to default whenever training passes through Detect.
// R10 - Result field: 0 pending, 1 success, 2 missed target, 3 no width change.
// R11 - Reserved bits read as zero and ignore writes.
package link_reconfig_pkg;
   localparam logic [11:0] CFG_OFFSET = 12'h530;
   localparam logic [11:0] STS_OFFSET = 12'h538;
   localparam logic [11:0] CTL_OFFSET = 12'h53c;
   localparam int INHIBIT_POS = 14;
   localparam int TARGET_LSB = 19;
   localparam int TARGET_MSB = 21;
   localparam int RESULT_LSB = 12;
   localparam int RESULT_MSB = 13;
   localparam int RETRAIN_POS = 0;
   localparam logic UP_INHIBIT_RST = 1'b1;
   localparam logic DN_INHIBIT_RST = 1'b0;
   localparam logic [2:0] TARGET_RST = 3'h7;
   localparam logic [1:0] RES_IDLE = 2'h0;
   localparam logic [1:0] RES_OK = 2'h1;
   localparam logic [1:0] RES_PARTIAL = 2'h2;
   localparam logic [1:0] RES_FAIL = 2'h3;
   localparam logic [3:0] LANES_MAX_CODE = 4'h0;
endpackage

// ===== link_width_speed_reconfig_ctl.sv
`timescale 1ns/100ps
module link_width_speed_reconfig_ctl
   import link_reconfig_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic clk_en_i,
   // Register port
   input wire logic [11:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // Link training side
   input wire logic is_upstream_i,
   input wire logic in_detect_i,
   input wire logic in_l0_i,
   input wire logic gen2_ok_i,
   input wire logic [5:0] negotiated_lane_count_i,
   input wire logic [5:0] max_lane_count_i,
   input wire logic reconfig_done_i,
   output logic speed_change_req_o,
   output logic width_change_req_o,
   output logic [5:0] target_lane_count_o
);

   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------
   function automatic logic [5:0] lanes_of(input logic [2:0] code, input logic [5:0] maxl);
      case (code)
         3'h0: lanes_of = 6'h01;
         3'h1: lanes_of = 6'h02;
         3'h2: lanes_of = 6'h04;
         3'h3: lanes_of = 6'h08;
         3'h7: lanes_of = maxl;
         default: lanes_of = 6'h00;
      endcase
   endfunction

   typedef enum logic [1:0] {WAIT_DET, WAIT_L0, DONE_SPD} spd_state_t;

   logic inhibit_r;
   logic [2:0] target_lane_count_r;
   logic [1:0] result_r;
   logic pending_r;
   logic strap_done_r;
   spd_state_t spd_r;
   logic [5:0] want_w;

   assign want_w = lanes_of(target_lane_count_r, max_lane_count_i); // R3 R4

   // A retrain write is taken only when no request is outstanding.
   logic retrain_take_w;
   logic service_w;

   assign retrain_take_w = wr_i && addr_i == CTL_OFFSET && wdata_i[RETRAIN_POS] && !pending_r;
   assign service_w = pending_r && reconfig_done_i;

   // ----------------------------------------------------------------
   // Speed change policy
   // ----------------------------------------------------------------
   // The upstream default is caught once after reset release, not under reset.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         inhibit_r <= DN_INHIBIT_RST;
         strap_done_r <= 1'b0;
      end
      else if (clk_en_i)
      begin
         if (!strap_done_r)
         begin
            strap_done_r <= 1'b1;
            inhibit_r <= is_upstream_i ? UP_INHIBIT_RST : DN_INHIBIT_RST; // R2
         end
         else if (wr_i && addr_i == CFG_OFFSET)
            inhibit_r <= wdata_i[INHIBIT_POS];
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         spd_r <= WAIT_DET;
         speed_change_req_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         speed_change_req_o <= 1'b0;
         case (spd_r)
            WAIT_DET:
            begin
               if (in_detect_i)
                  spd_r <= WAIT_L0;
            end
            WAIT_L0:
            begin
               if (in_l0_i)
               begin
                  spd_r <= DONE_SPD;
                  speed_change_req_o <= !inhibit_r && gen2_ok_i && strap_done_r; // R1 R2
               end
            end
            DONE_SPD:
            begin
               // Each new pass through Detect arms one more automatic request.
               if (in_detect_i)
                  spd_r <= WAIT_L0;
            end
            default:
            begin
               spd_r <= WAIT_DET;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Width reconfiguration
   // ----------------------------------------------------------------
   // Software alone keeps target and rate changes apart; nothing here checks it.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         target_lane_count_r <= TARGET_RST; // R4
      else if (clk_en_i)
      begin
         if (in_detect_i)
            target_lane_count_r <= TARGET_RST; // R9
         else if (wr_i && addr_i == CFG_OFFSET)
            target_lane_count_r <= wdata_i[TARGET_MSB:TARGET_LSB];
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         pending_r <= 1'b0;
      else if (clk_en_i)
      begin
         if (retrain_take_w)
            pending_r <= 1'b1; // R7
         else if (service_w)
            pending_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         width_change_req_o <= 1'b0;
      else if (clk_en_i)
         width_change_req_o <= retrain_take_w; // R7
   end

   // The lane count is latched at the request so that a later write cannot move it.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         target_lane_count_o <= 6'h00;
      else if (clk_en_i)
      begin
         if (retrain_take_w)
            target_lane_count_o <= want_w; // R3 R4
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         result_r <= RES_IDLE;
      else if (clk_en_i)
      begin
         if (retrain_take_w)
            result_r <= RES_IDLE; // R10
         else if (service_w)
         begin
            if (negotiated_lane_count_i == target_lane_count_o)
               result_r <= RES_OK; // R10
            else if (negotiated_lane_count_i != 6'h00 && in_l0_i)
               result_r <= RES_PARTIAL; // R10
            else
               result_r <= RES_FAIL; // R10
         end
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Fields are placed into a cleared word, so reserved bits can only read as zero.
   function automatic logic [31:0] read_word(input logic [11:0] addr);
      logic [31:0] word;
      word = 32'h0000_0000; // R11
      case (addr)
         CFG_OFFSET:
         begin
            word[INHIBIT_POS] = inhibit_r;
            word[TARGET_MSB:TARGET_LSB] = target_lane_count_r;
         end
         STS_OFFSET:
         begin
            word[RESULT_MSB:RESULT_LSB] = result_r;
         end
         CTL_OFFSET:
         begin
            word[RETRAIN_POS] = pending_r;
         end
         default:
         begin
            word = 32'h0000_0000;
         end
      endcase
      return word;
   endfunction

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         rdata_o <= 32'h0000_0000;
      else if (clk_en_i)
      begin
         if (rd_i)
            rdata_o <= read_word(addr_i);
         else
            rdata_o <= 32'h0000_0000; // R11
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // A taken retrain write, the first step of a width request.
   sequence s_retrain_write;
      clk_en_i && retrain_take_w;
   endsequence

   // The end of a serviced request.
   sequence s_service;
      clk_en_i && service_w;
   endsequence

   // The first L0 after a Detect pass with the automatic change allowed.
   sequence s_auto_l0_entry;
      clk_en_i && spd_r == WAIT_L0 && in_l0_i && !inhibit_r && gen2_ok_i && strap_done_r;
   endsequence

   chk_retrain_pulse: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R7
      width_change_req_o && $past(clk_en_i) |-> $past(wr_i) && $past(addr_i) == CTL_OFFSET)
      else $error("width change without retrain write");

   chk_retrain_issue: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R7
      s_retrain_write |=> width_change_req_o && pending_r && result_r == RES_IDLE)
      else $error("retrain write not turned into a width request");

   chk_width_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R7
      $past(clk_en_i) && !$past(retrain_take_w) |-> !width_change_req_o)
      else $error("width request without a taken retrain");

   chk_target_decode: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R3
      width_change_req_o && $past(clk_en_i) && $past(target_lane_count_r) < 3'h4 |->
         target_lane_count_o == 6'h01 << $past(target_lane_count_r))
      else $error("target lane count decoded wrongly");

   chk_pending_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R10
      s_service |=> !pending_r && result_r != RES_IDLE)
      else $error("serviced request still pending");

   chk_auto_speed: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R1
      s_auto_l0_entry |=> speed_change_req_o)
      else $error("automatic speed change not started");

   chk_inhibit_strap: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R2
      $rose(strap_done_r) && $past(is_upstream_i) |-> inhibit_r)
      else $error("upstream inhibit default not set");

   chk_strap_downstream: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R1
      $rose(strap_done_r) && !$past(is_upstream_i) |-> !inhibit_r)
      else $error("downstream inhibit default not clear");

   chk_reserved_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R11
      (rdata_o & 32'hffc7_8ffe) == 32'h0000_0000)
      else $error("reserved read bit not zero");

   chk_rdata_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R11
      $past(clk_en_i) && !$past(rd_i) |-> rdata_o == 32'h0000_0000)
      else $error("read data outside read cycle");

   chk_detect_default: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R9
      clk_en_i && in_detect_i |=> target_lane_count_r == TARGET_RST)
      else $error("target not defaulted in detect");
   chk_inhibit_blocks: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R2
      speed_change_req_o |-> !$past(inhibit_r))
      else $error("speed change while inhibited");
   chk_result_code: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R10
      $fell(pending_r) |-> result_r != RES_IDLE)
      else $error("result idle after service");
endmodule

// ===== tb.sv
`timescale 1ns/100ps
module tb
   import link_reconfig_pkg::*;
;
   logic clk_i = '0, rst_b_i = '0, wr = '0, rd = '0, up = '0, det = '0, l0 = '0, g2 = '0;
   logic done = '0, sc, wc;
   logic en = '1;
   logic [11:0] addr = '0;
   logic [31:0] wd = '0, rdat, q, r;
   logic [5:0] neg = '0, mx = 6'h10, tl;
   logic [2:0] c;
   int error_cnt = 0, n_compared = 0, nsc = 0;
   link_width_speed_reconfig_ctl DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .clk_en_i(en),
      .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat), .is_upstream_i(up),
      .in_detect_i(det), .in_l0_i(l0), .gen2_ok_i(g2), .negotiated_lane_count_i(neg),
      .max_lane_count_i(mx), .reconfig_done_i(done), .speed_change_req_o(sc),
      .width_change_req_o(wc), .target_lane_count_o(tl));
   initial
   begin
      forever #2 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (sc === 1'h1) nsc++;
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, s, e);
      end
   endtask
   // Every task ends one step past an edge, so no strobe is set twice at one edge.
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wr32(input logic [11:0] a, input logic [31:0] d);
      addr <= a;
      wd <= d;
      wr <= 1'h1;
      tick(1);
      wr <= 1'h0;
   endtask
   task automatic rd32(input logic [11:0] a);
      addr <= a;
      rd <= 1'h1;
      tick(1);
      rd <= 1'h0;
      q = rdat;
   endtask
   task automatic link_up();
      det <= 1'h1;
      tick(2);
      det <= 1'h0;
      l0 <= 1'h1;
      tick(8);
      l0 <= 1'h0;
      tick(2);
   endtask
   function automatic logic [5:0] lanes(input logic [2:0] k);
      return (k < 3'h4) ? 6'h1 << k : (k == 3'h7) ? mx : 6'h0;
   endfunction
   task give_verdict();
      if (error_cnt == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      #40000;
      error_cnt++;
      give_verdict();
   end
   initial
   begin
      void'($urandom(32'haaca751d));
      tick(3);
      rst_b_i <= 1'h1;
      tick(2);
      rd32(CFG_OFFSET);
      chk(q, 32'h0038_0000);
      tick(1);
      rd32(12'h7fc);
      chk(q, 32'h0);
      for (int i = 0; i < 8; i++)
      begin
         c = 3'(i);
         r = $urandom() & 32'hffc7_ffff | {10'h0, c, 19'h0};
         wr32(CFG_OFFSET, r);
         chk(wc, 32'h0);
         rd32(CFG_OFFSET);
         chk(q, r & 32'h0038_4000);
         neg <= ((c < 3'h4 || c == 3'h7) && $urandom_range(1)) ? lanes(c) : 6'h3f;
         wr32(CTL_OFFSET, 32'h1);
         chk({wc, tl}, {1'h1, lanes(c)});
         rd32(CTL_OFFSET);
         chk(q, 32'h1);
         l0 <= 1'($urandom_range(1));
         done <= 1'h1;
         tick(1);
         done <= 1'h0;
         tick(1);
         rd32(STS_OFFSET);
         chk(q, (neg == lanes(c)) ? 32'h1000 : l0 ? 32'h2000 : 32'h3000);
         l0 <= 1'h0;
      end
      wr32(CFG_OFFSET, 32'h0);
      g2 <= 1'h1;
      link_up();
      chk(nsc, 32'h1);
      rd32(CFG_OFFSET);
      chk(q, 32'h0038_0000);
      wr32(CFG_OFFSET, 32'h4000);
      link_up();
      chk(nsc, 32'h1);
      up <= 1'h1;
      rst_b_i <= 1'h0;
      tick(3);
      rst_b_i <= 1'h1;
      tick(2);
      rd32(CFG_OFFSET);
      chk(q, 32'h0038_4000);
      link_up();
      chk(nsc, 32'h1);
      en <= 1'h0;
      wr32(CFG_OFFSET, 32'h0);
      en <= 1'h1;
      rd32(CFG_OFFSET);
      chk(q, 32'h0038_4000);
      give_verdict();
   end
endmodule
